// ---- ceps_pkg.sv ----
// ****************************************************************
// Shared constants and types of the exception sequencer
// ****************************************************************
package ceps_pkg;

	// Slot stage codes
	typedef enum logic [1:0] {
		CEPS_ST_FETCH = 2'h0,	// Instruction fetch
		CEPS_ST_DEC   = 2'h1,	// decode_stage
		CEPS_ST_EXEC  = 2'h2,	// execute_stage
		CEPS_ST_MEM   = 2'h3	// memory_access_stage
	} ceps_stage_e;

	// Kind of sequence in progress
	typedef enum logic [2:0] {
		CEPS_K_NONE = 3'h0,	// No exception
		CEPS_K_INTR = 3'h1,	// Interrupt
		CEPS_K_ADDR = 3'h2,	// Address error
		CEPS_K_ILLG = 3'h3,	// Ordinary illegal instruction
		CEPS_K_SLOT = 3'h4	// Slot-illegal instruction
	} ceps_kind_e;

	// Sequencer states, Gray along idle-sequence and idle-powerdown
	typedef enum logic [1:0] {
		CEPS_S_IDLE = 2'h0,	// Normal issue
		CEPS_S_SEQ  = 2'h1,	// Exception slots running
		CEPS_S_PD   = 2'h2,	// Power-down execute slot
		CEPS_S_LOW  = 2'h3	// Sleep or standby
	} ceps_state_e;

	// Slot indices inside a sequence (0 is its own fetch)
	localparam logic [3:0] SLOT_FIRST_RUN = 4'h2;	// First slot after decode
	localparam logic [3:0] SLOT_LAST_LONG = 4'h9;	// Final execute, ten slots
	localparam logic [3:0] SLOT_LAST_ILL  = 4'h8;	// Final execute, nine slots

	// Stage maps, two bits per slot, slot 0 in the low bits
	localparam logic [19:0] MAP_LONG = 20'haefa4;	// F D E E M M E M E E
	localparam logic [19:0] MAP_ILL  = 20'h2bfa4;	// F D E E M M M E E

	// Access size codes
	localparam logic [1:0] SIZE_BYTE = 2'h0;	// Byte
	localparam logic [1:0] SIZE_WORD = 2'h1;	// Word
	localparam logic [1:0] SIZE_LONG = 2'h2;	// Longword

	// On-chip peripheral register windows (plain defaults)
	localparam logic [31:0] PERIPH_MASK  = 32'hffff_0000;	// Whole register space
	localparam logic [31:0] PERIPH_BASE  = 32'hffff_0000;
	localparam logic [31:0] PERIPH8_MASK = 32'hffff_ff00;	// 8-bit register space
	localparam logic [31:0] PERIPH8_BASE = 32'hffff_0000;

	// Number of external interrupt request pins besides the NMI pin
	localparam int IRQ_PINS = 4;

endpackage : ceps_pkg

// ---- ceps_addr_check.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Address error detection for fetch and data accesses
// ****************************************************************
module ceps_addr_check
	import ceps_pkg::*;
(
	// Fetch side
	input  logic        i_fetch_req,	// Fetch in this slot
	input  logic [31:0] i_fetch_addr,	// Fetch address
	// Data side
	input  logic        i_data_req,	// Data read or write
	input  logic [31:0] i_data_addr,	// Data address
	input  logic [1:0]  i_data_size,	// Access size code
	// Results
	output logic        o_fetch_err,	// Fetch address error
	output logic        o_data_err	// Data address error
);

	logic in_periph;	// Fetch hits register space
	logic in_periph8;	// Data hits 8-bit register space

	// Region decode
	assign in_periph  = (i_fetch_addr & PERIPH_MASK) == PERIPH_BASE;
	assign in_periph8 = (i_data_addr & PERIPH8_MASK) == PERIPH8_BASE;

	// Odd or peripheral fetch
	assign o_fetch_err = i_fetch_req && (i_fetch_addr[0] || in_periph);

	// Misaligned word, misaligned or 8-bit-space longword
	always_comb begin
		o_data_err = 1'b0;
		if (i_data_req) begin
			case (i_data_size)
				SIZE_WORD: o_data_err = i_data_addr[0];
				SIZE_LONG: o_data_err = (i_data_addr[1:0] != 2'h0) || in_periph8;
				default:   o_data_err = 1'b0;
			endcase
		end
	end

endmodule : ceps_addr_check

// ---- ceps_slot_decode.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Classification of illegal codes at the decode stage
// ****************************************************************
module ceps_slot_decode (
	// Decode stage facts
	input  logic i_valid,	// Instruction in decode
	input  logic i_undefined,	// Undefined opcode
	input  logic i_pc_write,	// Instruction rewrites the PC
	input  logic i_delay_slot,	// Sits in a delay slot
	// Results
	output logic o_illegal,	// Ordinary illegal
	output logic o_slot_illegal	// Slot-illegal
);

	// Undefined code outside a delay slot
	assign o_illegal = i_valid && i_undefined && !i_delay_slot;

	// Undefined or PC-writing code inside a delay slot
	assign o_slot_illegal = i_valid && i_delay_slot && (i_undefined || i_pc_write);

endmodule : ceps_slot_decode

// ---- ceps_sequencer.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Exception and power-down pipeline sequencer
// ****************************************************************

// Functional notes
// - Power-down runs fetch, decode, execute; reissued
// - After power-down, enter sleep or standby
// - Interrupt taken at decode, sequence replaces rest
// - Interrupt, address error: fixed ten slots
// - Interrupt: overrun fetch, not executed
// - Interrupt: destination fetch at final execute
// - Sources: pins, NMI, user break, peripherals
// - Address error taken at decode, replaces rest
// - Address error: overrun fetch, destination at last
// - Odd or peripheral fetch is address error
// - Misaligned word/long, long to 8-bit space
// - Illegal instruction: fixed nine slots
// - Illegal: one overrun, maybe a second
// - Illegal: destination fetch at final execute
// - Undefined code outside delay slot: illegal
// - Undefined or PC write in slot: slot-illegal
// - Memory access slots hold off fetch
module ceps_sequencer
	import ceps_pkg::*;
(
	// Clock and reset
	input  logic                     i_sys_clk,	// 100 MHz core clock
	input  logic                     i_reset_n,	// Synchronous, active low
	// Decode stage
	input  logic                     i_dec_valid,	// Instruction in decode
	input  logic                     i_dec_undefined,	// Undefined opcode
	input  logic                     i_dec_pc_write,	// Rewrites the PC
	input  logic                     i_dec_delay_slot,	// In a delay slot
	input  logic                     i_dec_sleep,	// Power-down instruction
	input  logic                     i_dec_two_ahead,	// Second overrun wanted
	input  logic                     i_standby_sel,	// 1 standby, 0 sleep
	// Interrupt sources
	input  logic                     i_nmi_pin,	// NMI pin, async
	input  logic [ceps_pkg::IRQ_PINS-1:0] i_irq_pins,	// Request pins, async
	input  logic                     i_user_break,	// User break
	input  logic                     i_periph_irq,	// Peripheral request
	// Memory bus side
	input  logic                     i_fetch_req,	// Fetch issued
	input  logic [31:0]              i_fetch_addr,	// Fetch address
	input  logic                     i_data_req,	// Data access issued
	input  logic [31:0]              i_data_addr,	// Data address
	input  logic [1:0]               i_data_size,	// Data size code
	// Sequencer outputs
	output logic                     o_fetch_en,	// Fetch may use the bus
	output logic                     o_mem_slot,	// Memory slot owns bus
	output ceps_pkg::ceps_stage_e    o_stage,	// Stage of current slot
	output ceps_pkg::ceps_kind_e     o_exc_kind,	// Sequence kind
	output logic                     o_seq_busy,	// Sequence running
	output logic                     o_discard,	// Drop overrun word
	output logic                     o_branch_fetch,	// Destination fetch
	// Power-down outputs
	output logic                     o_pd_issue,	// Power-down reissued
	output logic                     o_sleep_mode,	// In sleep
	output logic                     o_standby_mode,	// In standby
	// Error flags
	output logic                     o_ifetch_err,	// Fetch address error
	output logic                     o_data_err	// Data address error
);
	import ceps_pkg::*;

	// ************************************************************
	// Declarations
	// ************************************************************
	ceps_state_e           state_ff;	// Sequencer state
	ceps_state_e           nxt_state;
	logic [3:0]            slot_ff;	// Slot index
	logic [3:0]            nxt_slot;
	ceps_kind_e            kind_ff;	// Kind of sequence
	ceps_kind_e            nxt_kind;
	logic                  two_ff;	// Second overrun taken
	logic                  nxt_two;
	logic                  stby_ff;	// Standby chosen
	logic                  nmi_meta_ff;	// NMI first stage
	logic                  nmi_sync_ff;	// NMI second stage
	logic [IRQ_PINS-1:0]   irq_meta_ff;	// Pins first stage
	logic [IRQ_PINS-1:0]   irq_sync_ff;	// Pins second stage
	logic                  ae_pend_ff;	// Address error waiting
	logic                  fetch_err;	// Checker fetch error
	logic                  data_err;	// Checker data error
	logic                  illegal;	// Ordinary illegal
	logic                  slot_ill;	// Slot-illegal
	logic                  int_req;	// Any interrupt request
	logic                  ae_any;	// Address error now or waiting
	logic                  accept;	// Exception taken at decode
	logic                  pd_take;	// Power-down taken at decode
	logic [3:0]            last_slot;	// Final slot of the kind
	ceps_stage_e           nxt_stage;
	logic                  nxt_fetch_en;
	logic                  nxt_discard;
	logic                  nxt_branch;

	// ************************************************************
	// Helper modules
	// ************************************************************
	ceps_addr_check u_addr_check (
		.i_fetch_req  (i_fetch_req),
		.i_fetch_addr (i_fetch_addr),
		.i_data_req   (i_data_req),
		.i_data_addr  (i_data_addr),
		.i_data_size  (i_data_size),
		.o_fetch_err  (fetch_err),
		.o_data_err   (data_err)
	);

	ceps_slot_decode u_slot_decode (
		.i_valid        (i_dec_valid),
		.i_undefined    (i_dec_undefined),
		.i_pc_write     (i_dec_pc_write),
		.i_delay_slot   (i_dec_delay_slot),
		.o_illegal      (illegal),
		.o_slot_illegal (slot_ill)
	);

	// ************************************************************
	// Interrupt source synchronisers
	// ************************************************************

	// NMI pin through two flops
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			nmi_meta_ff <= 1'b0;
			nmi_sync_ff <= 1'b0;
		end else begin
			nmi_meta_ff <= i_nmi_pin;
			nmi_sync_ff <= nmi_meta_ff;
		end
	end

	// Request pins, one synchroniser each
	genvar gi;
	generate
		for (gi = 0; gi < IRQ_PINS; gi++) begin : g_irq_sync
			always_ff @(posedge i_sys_clk) begin
				if (!i_reset_n) begin
					irq_meta_ff[gi] <= 1'b0;
					irq_sync_ff[gi] <= 1'b0;
				end else begin
					irq_meta_ff[gi] <= i_irq_pins[gi];
					irq_sync_ff[gi] <= irq_meta_ff[gi];
				end
			end
		end
	endgenerate

	// Merge of all request sources
	assign int_req = nmi_sync_ff || (|irq_sync_ff) || i_user_break || i_periph_irq;

	// ************************************************************
	// Address error capture
	// ************************************************************

	// Hold an error until the next decode takes it; set wins
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			ae_pend_ff <= 1'b0;
		end else if (fetch_err || data_err) begin
			ae_pend_ff <= 1'b1;
		end else if (accept) begin
			ae_pend_ff <= 1'b0;
		end
	end

	// Error flags to the outside
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			o_ifetch_err <= 1'b0;
			o_data_err   <= 1'b0;
		end else begin
			o_ifetch_err <= fetch_err;
			o_data_err   <= data_err;
		end
	end

	// ************************************************************
	// Acceptance at decode
	// ************************************************************
	assign ae_any  = ae_pend_ff || fetch_err || data_err;
	assign accept  = (state_ff == CEPS_S_IDLE) && i_dec_valid &&
	                 (ae_any || illegal || slot_ill || int_req);
	assign pd_take = (state_ff == CEPS_S_IDLE) && i_dec_valid && i_dec_sleep && !accept;
	assign last_slot = ((kind_ff == CEPS_K_ILLG) || (kind_ff == CEPS_K_SLOT)) ?
	                   SLOT_LAST_ILL : SLOT_LAST_LONG;

	// ************************************************************
	// Next state
	// ************************************************************

	// State, slot and kind stepping
	always_comb begin
		nxt_state = state_ff;
		nxt_slot  = slot_ff;
		nxt_kind  = kind_ff;
		nxt_two   = two_ff;
		case (state_ff)
			CEPS_S_IDLE: begin
				// Address error first, then illegal, then interrupt
				if (accept) begin
					nxt_state = CEPS_S_SEQ;
					nxt_slot  = SLOT_FIRST_RUN;
					nxt_two   = 1'b0;
					if (ae_any) begin
						nxt_kind = CEPS_K_ADDR;
					end else if (slot_ill) begin
						nxt_kind = CEPS_K_SLOT;
					end else if (illegal) begin
						nxt_kind = CEPS_K_ILLG;
						nxt_two  = i_dec_two_ahead;
					end else begin
						nxt_kind = CEPS_K_INTR;
					end
				end else if (pd_take) begin
					nxt_state = CEPS_S_PD;
				end
			end
			CEPS_S_SEQ: begin
				// Step to the final execute slot, then resume
				if (slot_ff == last_slot) begin
					nxt_state = CEPS_S_IDLE;
					nxt_kind  = CEPS_K_NONE;
				end else begin
					nxt_slot = slot_ff + 4'h1;
				end
			end
			CEPS_S_PD: begin
				// Execute slot done, drop to low power
				nxt_state = CEPS_S_LOW;
			end
			CEPS_S_LOW: begin
				// Any request wakes the core
				if (int_req) begin
					nxt_state = CEPS_S_IDLE;
				end
			end
			default: begin
				nxt_state = CEPS_S_IDLE;
			end
		endcase
	end

	// Slot outputs for the next cycle
	always_comb begin
		nxt_stage    = CEPS_ST_FETCH;
		nxt_fetch_en = 1'b0;
		nxt_discard  = 1'b0;
		nxt_branch   = 1'b0;
		case (nxt_state)
			CEPS_S_IDLE: begin
				nxt_fetch_en = 1'b1;
			end
			CEPS_S_SEQ: begin
				// Stage from the map of the kind
				if ((nxt_kind == CEPS_K_ILLG) || (nxt_kind == CEPS_K_SLOT)) begin
					nxt_stage = ceps_stage_e'(MAP_ILL[{nxt_slot, 1'b0} +: 2]);
				end else begin
					nxt_stage = ceps_stage_e'(MAP_LONG[{nxt_slot, 1'b0} +: 2]);
				end
				// Word fetched at decode is an overrun, dropped
				nxt_discard = (nxt_slot == SLOT_FIRST_RUN) ||
				              (nxt_two && (nxt_slot == SLOT_FIRST_RUN + 4'h1));
				// Second overrun fetch for some illegal codes
				nxt_fetch_en = nxt_two && (nxt_slot == SLOT_FIRST_RUN);
				// Destination fetch in the final execute slot
				if (((nxt_kind == CEPS_K_ILLG) || (nxt_kind == CEPS_K_SLOT)) ?
				    (nxt_slot == SLOT_LAST_ILL) : (nxt_slot == SLOT_LAST_LONG)) begin
					nxt_branch   = 1'b1;
					nxt_fetch_en = 1'b1;
				end
				// Memory slots keep the bus away from fetch
				if (nxt_stage == CEPS_ST_MEM) begin
					nxt_fetch_en = 1'b0;
				end
			end
			CEPS_S_PD: begin
				nxt_stage = CEPS_ST_EXEC;
			end
			default: begin
				nxt_fetch_en = 1'b0;
			end
		endcase
	end

	// ************************************************************
	// State registers
	// ************************************************************

	// Sequencer state
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			state_ff <= CEPS_S_IDLE;
			slot_ff  <= 4'h0;
			kind_ff  <= CEPS_K_NONE;
			two_ff   <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			slot_ff  <= nxt_slot;
			kind_ff  <= nxt_kind;
			two_ff   <= nxt_two;
		end
	end

	// Standby choice caught with the power-down decode
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			stby_ff <= 1'b0;
		end else if (pd_take) begin
			stby_ff <= i_standby_sel;
		end
	end

	// ************************************************************
	// Output registers
	// ************************************************************

	// Pipeline control outputs
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			o_fetch_en     <= 1'b0;
			o_mem_slot     <= 1'b0;
			o_stage        <= CEPS_ST_FETCH;
			o_exc_kind     <= CEPS_K_NONE;
			o_seq_busy     <= 1'b0;
			o_discard      <= 1'b0;
			o_branch_fetch <= 1'b0;
		end else begin
			o_fetch_en     <= nxt_fetch_en;
			o_mem_slot     <= (nxt_state == CEPS_S_SEQ) && (nxt_stage == CEPS_ST_MEM);
			o_stage        <= nxt_stage;
			o_exc_kind     <= nxt_kind;
			o_seq_busy     <= nxt_state == CEPS_S_SEQ;
			o_discard      <= nxt_discard;
			o_branch_fetch <= nxt_branch;
		end
	end

	// Power-down outputs; reissue lasts until next fetch
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			o_pd_issue     <= 1'b0;
			o_sleep_mode   <= 1'b0;
			o_standby_mode <= 1'b0;
		end else begin
			o_pd_issue     <= (nxt_state == CEPS_S_PD) || (nxt_state == CEPS_S_LOW);
			o_sleep_mode   <= (nxt_state == CEPS_S_LOW) && !(pd_take ? i_standby_sel : stby_ff);
			o_standby_mode <= (nxt_state == CEPS_S_LOW) && (pd_take ? i_standby_sel : stby_ff);
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);

	a_intr_take_dec: assert property (
		accept && !ae_any && !illegal && !slot_ill |=> o_seq_busy && o_exc_kind == CEPS_K_INTR)
		else $error("interrupt not taken at decode");
	a_long_stage_seq: assert property (
		$rose(o_seq_busy) && (o_exc_kind == CEPS_K_INTR || o_exc_kind == CEPS_K_ADDR)
		|-> o_stage == CEPS_ST_EXEC ##1 o_stage == CEPS_ST_EXEC ##1 o_stage == CEPS_ST_MEM [*2]
		##1 o_stage == CEPS_ST_EXEC ##1 o_stage == CEPS_ST_MEM ##1 o_stage == CEPS_ST_EXEC [*2])
		else $error("ten slot order broken");
	a_long_branch_at: assert property (
		$rose(o_seq_busy) && o_exc_kind != CEPS_K_ILLG && o_exc_kind != CEPS_K_SLOT
		|-> !o_branch_fetch [*7] ##1 o_branch_fetch)
		else $error("destination fetch not at final execute");
	a_ill_stage_seq: assert property (
		$rose(o_seq_busy) && (o_exc_kind == CEPS_K_ILLG || o_exc_kind == CEPS_K_SLOT)
		|-> o_stage == CEPS_ST_EXEC [*2] ##1 o_stage == CEPS_ST_MEM [*3]
		##1 o_stage == CEPS_ST_EXEC ##1 o_stage == CEPS_ST_EXEC && o_branch_fetch)
		else $error("nine slot order broken");
	a_overrun_drop: assert property (
		$rose(o_seq_busy) |-> o_discard)
		else $error("overrun word not discarded");
	a_mem_no_fetch: assert property (
		o_mem_slot |-> !o_fetch_en)
		else $error("fetch during memory slot");
	a_pd_then_low: assert property (
		$rose(o_pd_issue) |-> !o_fetch_en ##1 (o_sleep_mode ^ o_standby_mode))
		else $error("power-down did not reach low power");
	a_slot_ill_kind: assert property (
		accept && !ae_any && slot_ill |=> o_exc_kind == CEPS_K_SLOT)
		else $error("slot-illegal not raised");
	a_ae_kind: assert property (
		accept && ae_any |=> o_exc_kind == CEPS_K_ADDR)
		else $error("address error not taken");

	c_intr_seq: cover property ($rose(o_seq_busy) && o_exc_kind == CEPS_K_INTR);
	c_ill_two:  cover property ($rose(o_seq_busy) && two_ff && o_fetch_en ##1 o_discard);
	c_pd_wake:  cover property (o_sleep_mode ##1 !o_pd_issue);
	c_ae_seq:   cover property ($rose(o_seq_busy) && o_exc_kind == CEPS_K_ADDR);

endmodule : ceps_sequencer

// ---- ceps_bus_model.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Memory bus model: fetch stream plus injected accesses
// ****************************************************************
module ceps_bus_model (
	// Clock and reset
	input  logic        i_sys_clk,
	input  logic        i_reset_n,
	// Grant and injection
	input  logic        i_fetch_en,	// Bus free for fetch
	input  logic        i_cmd_valid,	// Inject one access
	input  logic        i_cmd_data,	// 1 data, 0 fetch
	input  logic [31:0] i_cmd_addr,
	input  logic [1:0]  i_cmd_size,
	// Bus requests
	output logic        o_fetch_req,
	output logic [31:0] o_fetch_addr,
	output logic        o_data_req,
	output logic [31:0] o_data_addr,
	output logic [1:0]  o_data_size
);
	logic [31:0] pc_ff;	// Next sequential fetch address

	// One request per slot; released lines flip so stale values never match
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			pc_ff        <= 32'h0000_1000;
			o_fetch_req  <= 1'b0;
			o_data_req   <= 1'b0;
			o_fetch_addr <= 32'h0;
			o_data_addr  <= 32'h0;
			o_data_size  <= 2'h0;
		end else if (i_cmd_valid) begin
			o_fetch_req  <= !i_cmd_data;
			o_data_req   <= i_cmd_data;
			o_fetch_addr <= i_cmd_addr;
			o_data_addr  <= i_cmd_addr;
			o_data_size  <= i_cmd_size;
		end else begin
			o_fetch_req  <= i_fetch_en;
			o_data_req   <= 1'b0;
			o_fetch_addr <= i_fetch_en ? pc_ff : ~o_fetch_addr;
			o_data_addr  <= ~o_data_addr;
			if (i_fetch_en)
				pc_ff <= pc_ff + 32'h2;
		end
	end
endmodule : ceps_bus_model

// ---- cpu_exception_pipeline_sequencer_test.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench of the exception sequencer
// ****************************************************************
module cpu_exception_pipeline_sequencer_test;
	import ceps_pkg::*;
	// Decode bits {undef,pc_write,delay_slot,two_ahead}, source, kind
	typedef struct {
		logic [3:0] dec;
		int         src;
		ceps_kind_e kind;
	} ceps_row_s;
	logic i_sys_clk, i_reset_n, i_dec_valid, i_dec_undefined, i_dec_pc_write;
	logic i_dec_delay_slot, i_dec_sleep, i_dec_two_ahead, i_standby_sel;
	logic i_nmi_pin, i_user_break, i_periph_irq, cmd_valid, cmd_data;
	logic [3:0] i_irq_pins;
	logic [31:0] cmd_addr, fetch_addr, data_addr;
	logic [1:0] cmd_size, data_size;
	logic fetch_req, data_req, o_fetch_en, o_mem_slot, o_seq_busy, o_discard;
	logic o_branch_fetch, o_pd_issue, o_sleep_mode, o_standby_mode;
	logic o_ifetch_err, o_data_err;
	ceps_stage_e o_stage;
	ceps_kind_e o_exc_kind;
	int bad_count = 0;
	int checked = 0;
	// Sources: 1 nmi 2 pin 3 break 4 periph, 5..9 faulting accesses
	ceps_row_s rows [13] = '{
		'{4'h8, 0, CEPS_K_ILLG}, '{4'h9, 0, CEPS_K_ILLG},
		'{4'ha, 0, CEPS_K_SLOT}, '{4'h6, 0, CEPS_K_SLOT},
		'{4'h0, 1, CEPS_K_INTR}, '{4'h0, 2, CEPS_K_INTR},
		'{4'h0, 3, CEPS_K_INTR}, '{4'h0, 4, CEPS_K_INTR},
		'{4'h0, 5, CEPS_K_ADDR}, '{4'h0, 6, CEPS_K_ADDR},
		'{4'h0, 7, CEPS_K_ADDR}, '{4'h0, 8, CEPS_K_ADDR},
		'{4'h0, 9, CEPS_K_ADDR}};
	ceps_row_s wake_row = '{4'h0, 4, CEPS_K_INTR};
	logic [31:0] ok_addr [3] = '{32'h0000_2003, 32'hffff_0104, 32'h0000_2002};
	logic [1:0] ok_size [3] = '{SIZE_BYTE, SIZE_LONG, SIZE_WORD};

	ceps_sequencer u_ceps_sequencer (.i_sys_clk, .i_reset_n, .i_dec_valid,
		.i_dec_undefined, .i_dec_pc_write, .i_dec_delay_slot, .i_dec_sleep,
		.i_dec_two_ahead, .i_standby_sel, .i_nmi_pin, .i_irq_pins, .i_user_break,
		.i_periph_irq, .i_fetch_req(fetch_req), .i_fetch_addr(fetch_addr),
		.i_data_req(data_req), .i_data_addr(data_addr), .i_data_size(data_size),
		.o_fetch_en, .o_mem_slot, .o_stage, .o_exc_kind, .o_seq_busy, .o_discard,
		.o_branch_fetch, .o_pd_issue, .o_sleep_mode, .o_standby_mode,
		.o_ifetch_err, .o_data_err);
	ceps_bus_model u_ceps_bus_model (.i_sys_clk, .i_reset_n, .i_fetch_en(o_fetch_en),
		.i_cmd_valid(cmd_valid), .i_cmd_data(cmd_data), .i_cmd_addr(cmd_addr),
		.i_cmd_size(cmd_size), .o_fetch_req(fetch_req), .o_fetch_addr(fetch_addr),
		.o_data_req(data_req), .o_data_addr(data_addr), .o_data_size(data_size));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check
	task automatic step;
		@(posedge i_sys_clk);
		#1;
	endtask : step
	task automatic give_verdict;
		$display("checks %0d errors %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	// Raise one exception, then follow its slots to the end
	task automatic run_row(input ceps_row_s r);
		string seq;
		logic mem, last, two;
		two = r.dec[0];
		seq = (r.kind inside {CEPS_K_ILLG, CEPS_K_SLOT}) ? "EEMMMEE" : "EEMMEMEE";
		if (r.src >= 5) begin
			cmd_valid = 1;
			cmd_data = r.src >= 7;
			cmd_size = (r.src == 7) ? SIZE_WORD : SIZE_LONG;
			case (r.src)
				5: cmd_addr = 32'h0000_1001;
				6: cmd_addr = 32'hffff_0010;
				7: cmd_addr = 32'h0000_2003;
				8: cmd_addr = 32'h0000_2002;
				default: cmd_addr = 32'hffff_0004;
			endcase
			step();
			cmd_valid = 0;
			step();
			check("addr_err", 1, cmd_data ? o_data_err : o_ifetch_err);
		end
		{i_dec_undefined, i_dec_pc_write, i_dec_delay_slot, i_dec_two_ahead} = r.dec;
		i_nmi_pin = r.src == 1;
		i_irq_pins = (r.src == 2) ? 4'h4 : 4'h0;
		i_user_break = r.src == 3;
		i_periph_irq = r.src == 4;
		i_dec_valid = 1;
		for (int i = 0; i < 8 && o_seq_busy !== 1'b1; i++)
			step();
		{i_dec_valid, i_nmi_pin, i_irq_pins, i_user_break, i_periph_irq} = 8'h0;
		{i_dec_undefined, i_dec_pc_write, i_dec_delay_slot, i_dec_two_ahead} = 4'h0;
		check("kind", r.kind, o_exc_kind);
		for (int k = 1; k <= seq.len(); k++) begin
			if (k > 1)
				step();
			mem = seq[k-1] == "M";
			last = k == seq.len();
			check("stage", mem ? CEPS_ST_MEM : CEPS_ST_EXEC, o_stage);
			check("mem_slot", mem, o_mem_slot);
			check("fetch_en", last || (k == 1 && two), o_fetch_en);
			check("discard", k == 1 || (k == 2 && two), o_discard);
			check("branch", last, o_branch_fetch);
			check("busy", 1, o_seq_busy);
		end
		step();
		check("busy_end", 0, o_seq_busy);
	endtask : run_row

	// ****************************************************************
	// Clock, watchdog and main sequence
	// ****************************************************************
	initial begin
		i_sys_clk = 0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	initial begin
		repeat (3000) @(posedge i_sys_clk);
		bad_count++;
		give_verdict();
	end
	initial begin
		{i_reset_n, i_dec_valid, i_dec_undefined, i_dec_pc_write} = 4'h0;
		{i_dec_delay_slot, i_dec_sleep, i_dec_two_ahead, i_standby_sel} = 4'h0;
		{i_nmi_pin, i_irq_pins, i_user_break, i_periph_irq} = 7'h0;
		{cmd_valid, cmd_data, cmd_addr, cmd_size} = 36'h0;
		repeat (3) @(posedge i_sys_clk);
		#1;
		check("rst_busy", 0, o_seq_busy);
		check("rst_stage", CEPS_ST_FETCH, o_stage);
		i_reset_n = 1;
		check("fetch_en_1", 0, o_fetch_en);
		step();
		check("fetch_en_2", 1, o_fetch_en);
		foreach (rows[i])
			run_row(rows[i]);
		// Legal accesses and a PC write outside a delay slot stay quiet
		foreach (ok_addr[j]) begin
			{cmd_valid, cmd_data, cmd_addr, cmd_size} = {2'h3, ok_addr[j], ok_size[j]};
			step();
			cmd_valid = 0;
			step();
			check("no_data_err", 0, o_data_err);
		end
		{i_dec_valid, i_dec_pc_write} = 2'h3;
		step();
		step();
		{i_dec_valid, i_dec_pc_write} = 2'h0;
		check("pcw_quiet", 0, o_seq_busy);
		// Power-down into sleep, then standby, woken by a request
		for (int s = 0; s < 2; s++) begin
			{i_standby_sel, i_dec_sleep, i_dec_valid} = {s[0], 2'h3};
			step();
			{i_dec_sleep, i_dec_valid} = 2'h0;
			check("pd_issue", 1, o_pd_issue);
			check("pd_fetch_en", 0, o_fetch_en);
			check("pd_stage", CEPS_ST_EXEC, o_stage);
			step();
			check("pd_hold", 1, o_pd_issue);
			check("standby", s[0], o_standby_mode);
			check("sleep", !s[0], o_sleep_mode);
			{i_dec_valid, i_dec_undefined} = 2'h3;
			step();
			step();
			{i_dec_valid, i_dec_undefined} = 2'h0;
			check("pd_refuse", 0, o_seq_busy);
			i_periph_irq = 1;
			for (int i = 0; i < 4 && o_pd_issue === 1'b1; i++)
				step();
			check("wake_mode", 0, o_sleep_mode | o_standby_mode);
			check("wake_fetch_en", 1, o_fetch_en);
			run_row(wake_row);
		end
		give_verdict();
	end
endmodule : cpu_exception_pipeline_sequencer_test
